// File: bench/supply_comparator_model.sv
// behavioural analog comparator: supply against the selected threshold
`timescale 1ns/100ps
module supply_comparator_model
(
   // analog side
   input var int supply_mv,
   // control from the monitor
   input wire logic enable,
   input wire logic low_sel,
   output logic below
);
   // a powered-down comparator is held low, so no stale level leaks out
   always_comb below = enable && (supply_mv < (low_sel ? 2300 : 2800));
endmodule : supply_comparator_model

// File: bench/supply_monitor_props.sv
// concurrent checks on the supply monitor top ports
`timescale 1ns/100ps
module supply_monitor_props
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   // register port
   input wire supply_monitor_pkg::addr_t ADDR,
   input wire logic WR,
   input wire logic RD,
   // comparator and system
   input wire logic COMPARATOR_BELOW,
   input wire logic COMPARATOR_ENABLE,
   input wire logic THRESHOLD_LOW_SEL,
   input wire logic SUPPLY_LOW_RESET,
   input wire logic IRQ
);
   import supply_monitor_pkg::*;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   logic pin_r;
   logic [3:0] calm_r;
   // quiet time of the pin, so a crossing still in the filter cannot refill the status
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         pin_r <= 1'b0;
         calm_r <= 4'h0;
      end
      else
      begin
         pin_r <= COMPARATOR_BELOW;
         calm_r <= (COMPARATOR_BELOW != pin_r) ? 4'h0 : calm_r + {3'h0, calm_r != 4'hf};
      end
   end
   sequence prot_wr_s;
      WR && ADDR == PROT_CMD_ADDR;
   endsequence
   sequence ctrl_wr_s;
      WR && ADDR == CTRL_ADDR;
   endsequence
   reset_needs_en_a: assert property (SUPPLY_LOW_RESET |-> COMPARATOR_ENABLE)
      else $error("reset request while disabled");
   reset_sync_a: assert property ($rose(SUPPLY_LOW_RESET) |-> $past(COMPARATOR_BELOW, 2))
      else $error("reset request ahead of synchroniser");
   reset_release_a: assert property ($fell(SUPPLY_LOW_RESET) |-> !$past(COMPARATOR_BELOW, 2))
      else $error("reset request dropped while below");
   lock_enable_a: assert property (SUPPLY_LOW_RESET |=> COMPARATOR_ENABLE [*3])
      else $error("enable lost while locked");
   lock_level_a: assert property (SUPPLY_LOW_RESET |=> $stable(THRESHOLD_LOW_SEL))
      else $error("level changed while locked");
   ctrl_protect_a: assert property (WR && ADDR == CTRL_ADDR
      && !($past(WR) && $past(ADDR) == PROT_CMD_ADDR) |=> $stable(COMPARATOR_ENABLE))
      else $error("unprotected control write took effect");
   enable_cause_a: assert property ($changed(COMPARATOR_ENABLE)
      |-> $past(WR) && $past(ADDR) == CTRL_ADDR)
      else $error("enable moved without control write");
   level_cause_a: assert property ($changed(THRESHOLD_LOW_SEL)
      |-> $past(WR) && $past(ADDR) == LEVEL_ADDR)
      else $error("threshold moved without level write");
   irq_clear_a: assert property (RD && ADDR == IRQ_STATUS_ADDR && !$past(WR)
      && !$past(WR, 2) && calm_r > 4'h6 |=> !IRQ)
      else $error("interrupt stayed after status read");
   cover property (prot_wr_s ##1 ctrl_wr_s);
endmodule : supply_monitor_props

// File: bench/supply_monitor_tb.sv
// self-checking bench for the supply monitor with a comparator model
`timescale 1ns/100ps
module supply_monitor_tb;
   import supply_monitor_pkg::*;
   logic CLOCK = 1'b0;
   logic ARST_N = 1'b0;
   addr_t ADDR = '0;
   byte_t WDATA = '0;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic BIT_WR = 1'b0;
   bit_sel_t BIT_SEL = '0;
   byte_t RDATA;
   logic COMPARATOR_BELOW, COMPARATOR_ENABLE, THRESHOLD_LOW_SEL, SUPPLY_LOW_RESET, IRQ;
   int supply_mv = 3000;
   int fail_count = 0;
   int total_checks = 0;
   int seed = 32'h5e09;
   int stat_m, prev_m, cur_m;
   always #2 CLOCK = ~CLOCK;
   supply_monitor i_dut (.CLOCK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .BIT_WR, .BIT_SEL, .RDATA,
      .COMPARATOR_BELOW, .COMPARATOR_ENABLE, .THRESHOLD_LOW_SEL, .SUPPLY_LOW_RESET, .IRQ);
   supply_comparator_model i_cmp (.supply_mv, .enable(COMPARATOR_ENABLE),
      .low_sel(THRESHOLD_LOW_SEL), .below(COMPARATOR_BELOW));
   task automatic check(input string what, input byte_t seen, input byte_t exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(posedge CLOCK);
   endtask : cyc
   // p puts the command write in the cycle right before the target; bs[3] marks a bit write
   task automatic wr(input addr_t a, input byte_t d, input bit p, input logic [3:0] bs);
      @(posedge CLOCK);
      if (p)
      begin
         WR <= 1'b1;
         ADDR <= PROT_CMD_ADDR;
         @(posedge CLOCK);
      end
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      BIT_WR <= bs[3];
      BIT_SEL <= bs[2:0];
      @(posedge CLOCK);
      WR <= 1'b0;
      BIT_WR <= 1'b0;
   endtask : wr
   task automatic rd(input addr_t a, input byte_t exp, input string what);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 check(what, RDATA, exp);
   endtask : rd
   task automatic do_reset;
      ARST_N <= 1'b0;
      cyc(10);
      ARST_N <= 1'b1;
   endtask : do_reset
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : summarize
   initial
   begin
      #100000;
      fail_count++;
      summarize();
   end
   initial
   begin
      do_reset();
      rd(CTRL_ADDR, 8'h00, "ctrl reset");
      rd(LEVEL_ADDR, 8'h00, "level reset");
      rd(32'hfffff8f0, 8'h00, "unmapped");
      wr(CTRL_ADDR, 8'h80, 1'b0, 4'h0);
      rd(CTRL_ADDR, 8'h00, "ctrl unprotected");
      rd(IRQ_STATUS_ADDR, 8'h02, "violation flag");
      wr(LEVEL_ADDR, 8'h01, 1'b0, 4'h0);
      wr(LEVEL_ADDR, 8'h00, 1'b0, 4'h8);
      rd(LEVEL_ADDR, 8'h01, "level bit write");
      check("low select", {7'h00, THRESHOLD_LOW_SEL}, 8'h01);
      wr(CTRL_ADDR, 8'h01, 1'b1, 4'hf);
      wr(CTRL_ADDR, 8'h01, 1'b1, 4'h8);
      // settle time shortened; the flag is only trusted after this wait
      cyc(12);
      rd(CTRL_ADDR, 8'h80, "ctrl bit writes");
      rd(IRQ_STATUS_ADDR, 8'h00, "status before unmask");
      wr(IRQ_MASK_ADDR, 8'h01, 1'b0, 4'h0);
      prev_m = 0;
      repeat (8)
      begin
         supply_mv <= 2050 + ($random(seed) & 511);
         cyc(12);
         cur_m = supply_mv < 2300;
         stat_m = cur_m != prev_m;
         prev_m = cur_m;
         check("irq", {7'h00, IRQ}, stat_m[7:0]);
         rd(IRQ_STATUS_ADDR, stat_m[7:0], "crossing flag");
         rd(CTRL_ADDR, 8'h80 | cur_m[7:0], "below flag");
      end
      // leave interrupt mode only with the supply back above the threshold
      supply_mv <= 3000;
      cyc(12);
      rd(IRQ_STATUS_ADDR, prev_m[7:0], "rising crossing");
      wr(CTRL_ADDR, 8'h00, 1'b1, 4'h0);
      supply_mv <= 2000;
      cyc(12);
      rd(CTRL_ADDR, 8'h00, "flag disabled");
      check("irq disabled", {7'h00, IRQ}, 8'h00);
      wr(IRQ_MASK_ADDR, 8'h00, 1'b0, 4'h0);
      supply_mv <= 3000;
      wr(CTRL_ADDR, 8'h80, 1'b1, 4'h0);
      cyc(12);
      rd(CTRL_ADDR, 8'h80, "above before arming");
      wr(CTRL_ADDR, 8'h82, 1'b1, 4'h0);
      wr(LEVEL_ADDR, 8'h00, 1'b0, 4'h0);
      wr(CTRL_ADDR, 8'h00, 1'b1, 4'h0);
      rd(CTRL_ADDR, 8'h82, "ctrl locked");
      rd(LEVEL_ADDR, 8'h01, "level locked");
      supply_mv <= 2000;
      cyc(12);
      check("reset request", {7'h00, SUPPLY_LOW_RESET}, 8'h01);
      supply_mv <= 3000;
      cyc(12);
      check("reset ends", {7'h00, SUPPLY_LOW_RESET}, 8'h00);
      rd(CTRL_ADDR, 8'h82, "ctrl monitor reset");
      rd(CAUSE_ADDR, 8'h01, "cause flag");
      rd(LEVEL_ADDR, 8'h01, "level kept");
      do_reset();
      rd(CTRL_ADDR, 8'h00, "ctrl other reset");
      rd(LEVEL_ADDR, 8'h00, "level other reset");
      rd(CAUSE_ADDR, 8'h00, "cause other reset");
      summarize();
   end
endmodule : supply_monitor_tb
bind supply_monitor supply_monitor_props u_props (.CLOCK, .ARST_N, .ADDR, .WR, .RD,
   .COMPARATOR_BELOW, .COMPARATOR_ENABLE, .THRESHOLD_LOW_SEL, .SUPPLY_LOW_RESET, .IRQ);

// File: logic/input_filter.sv
// three-stage synchroniser with agreement filter for an asynchronous level
`timescale 1ns/100ps
module input_filter
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // level in and out
   input wire logic din,
   output logic dout
);
   import supply_monitor_pkg::*;

   logic [SYNC_STAGES-1:0] stage_r;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         stage_r <= '0;
      end
      else
      begin
         stage_r <= {stage_r[SYNC_STAGES-2:0], din};
      end
   end

   // the output moves only when the last two stages agree
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dout <= 1'b0;
      end
      else if (stage_r[SYNC_STAGES-1] == stage_r[SYNC_STAGES-2])
      begin
         dout <= stage_r[SYNC_STAGES-1];
      end
   end
endmodule : input_filter

// File: logic/prot_if.sv
// signals between the register core and the protected write sequencer
`timescale 1ns/100ps
interface prot_if;
   logic wr;
   logic rd;
   logic hit_cmd;
   logic hit_ctrl;
   logic accept;
   logic violation;

   modport core
   (
      output wr,
      output rd,
      output hit_cmd,
      output hit_ctrl,
      input accept,
      input violation
   );

   modport seq
   (
      input wr,
      input rd,
      input hit_cmd,
      input hit_ctrl,
      output accept,
      output violation
   );
endinterface : prot_if

// File: logic/prot_sequencer.sv
// protected special-register write sequence: command write, then the target write
`timescale 1ns/100ps
module prot_sequencer
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sync_clear,
   // bus view
   prot_if.seq bus
);
   import supply_monitor_pkg::*;

   typedef enum logic {IDLE, ARMED} seq_state_t;

   seq_state_t state_r;
   seq_state_t state_nxt;

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         IDLE:
         begin
            if (bus.wr && bus.hit_cmd)
            begin
               state_nxt = ARMED;
            end
         end
         ARMED:
         begin
            // any access right after the command disarms, whether it hits or not, except another command write, which keeps it armed
            if (bus.wr && bus.hit_cmd)
            begin
               state_nxt = ARMED;
            end
            else if (bus.wr || bus.rd)
            begin
               state_nxt = IDLE;
            end
         end
         default:
         begin
            state_nxt = IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= IDLE;
      end
      else if (sync_clear)
      begin
         state_r <= IDLE;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   assign bus.accept = bus.wr && bus.hit_ctrl && (state_r == ARMED);
   assign bus.violation = bus.wr && bus.hit_ctrl && (state_r != ARMED);
endmodule : prot_sequencer

// File: logic/supply_monitor.sv
// supply voltage monitor: control, level select, reset cause and interrupt logic
`timescale 1ns/100ps
module supply_monitor
(
   // clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   // register port
   input wire supply_monitor_pkg::addr_t ADDR,
   input wire supply_monitor_pkg::byte_t WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic BIT_WR,
   input wire supply_monitor_pkg::bit_sel_t BIT_SEL,
   output supply_monitor_pkg::byte_t RDATA,
   // analog comparator
   input wire logic COMPARATOR_BELOW,
   output logic COMPARATOR_ENABLE,
   output logic THRESHOLD_LOW_SEL,
   // system
   output logic SUPPLY_LOW_RESET,
   output logic IRQ
);
   import supply_monitor_pkg::*;

   // merge a write into a register: byte write or single-bit write
   function automatic byte_t merge_write(input byte_t cur, input byte_t wdata,
                                         input logic bit_wr, input bit_sel_t sel,
                                         input byte_t wmask);
      byte_t res;
      res = cur;
      if (bit_wr)
      begin
         res[sel] = wdata[0];
      end
      else
      begin
         res = wdata;
      end
      merge_write = (res & wmask) | (cur & ~wmask);
   endfunction : merge_write

   // held state
   logic enable_r;
   logic mode_r;
   logic level_r;
   logic cause_r;
   byte_t irq_status_r;
   byte_t irq_mask_r;
   logic below_prev_r;
   logic enabled_prev_r;
   byte_t rdata_r;

   // derived
   logic below_sync;
   logic below_flag;
   logic locked;
   logic monitor_reset;
   logic cross_event;
   logic hit_ctrl;
   logic hit_level;
   logic hit_cause;
   logic hit_irq_status;
   logic hit_irq_mask;
   logic hit_cmd;
   logic level_wr_ok;
   byte_t ctrl_view;
   byte_t ctrl_nxt;
   byte_t irq_status_nxt;
   byte_t read_mux;
   byte_t irq_set;

   prot_if prot ();

   // address decode
   assign hit_ctrl = (ADDR == CTRL_ADDR);
   assign hit_level = (ADDR == LEVEL_ADDR);
   assign hit_cause = (ADDR == CAUSE_ADDR);
   assign hit_irq_status = (ADDR == IRQ_STATUS_ADDR);
   assign hit_irq_mask = (ADDR == IRQ_MASK_ADDR);
   assign hit_cmd = (ADDR == PROT_CMD_ADDR);

   assign prot.wr = WR;
   assign prot.rd = RD;
   assign prot.hit_cmd = hit_cmd;
   assign prot.hit_ctrl = hit_ctrl;

   prot_sequencer u_prot
   (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .sync_clear(monitor_reset),
      .bus(prot.seq)
   );

   // the comparator toggles at any time against the clock
   input_filter u_below_sync
   (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .din(COMPARATOR_BELOW),
      .dout(below_sync)
   );

   // comparator is powered and its result used only while enabled
   assign COMPARATOR_ENABLE = enable_r;
   assign THRESHOLD_LOW_SEL = level_r;
   assign below_flag = enable_r & below_sync;

   // nothing here is gated by standby; the clock must keep running in STOP
   assign locked = enable_r & mode_r;
   assign monitor_reset = enable_r & mode_r & below_flag;
   assign SUPPLY_LOW_RESET = monitor_reset;

   // edge on the filtered level while enabled on both sides of the edge; an
   // enable change itself is not a crossing because the flag is then forced
   assign cross_event = enable_r & enabled_prev_r & ~mode_r
                        & (below_sync != below_prev_r);

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         below_prev_r <= 1'b0;
         enabled_prev_r <= 1'b0;
      end
      else
      begin
         below_prev_r <= below_sync;
         enabled_prev_r <= enable_r;
      end
   end

   // control register: only the enable and mode bits are stored
   assign ctrl_view = {enable_r, 5'h00, mode_r, below_flag};
   assign ctrl_nxt = merge_write(ctrl_view, WDATA, BIT_WR, BIT_SEL, CTRL_WMASK);

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         enable_r <= CTRL_RESET_OTHER[CTRL_ENABLE_BIT];
         mode_r <= CTRL_RESET_OTHER[CTRL_MODE_BIT];
      end
      else if (monitor_reset)
      begin
         enable_r <= CTRL_RESET_MONITOR[CTRL_ENABLE_BIT];
         mode_r <= CTRL_RESET_MONITOR[CTRL_MODE_BIT];
      end
      else if (prot.accept && !locked)
      begin
         enable_r <= ctrl_nxt[CTRL_ENABLE_BIT];
         mode_r <= ctrl_nxt[CTRL_MODE_BIT];
      end
   end

   // level select: byte writes only; a monitor reset leaves it alone
   assign level_wr_ok = WR & hit_level & ~BIT_WR & ~locked;

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         level_r <= LEVEL_RESET_OTHER[LEVEL_BIT];
      end
      else if (level_wr_ok)
      begin
         level_r <= WDATA[LEVEL_BIT];
      end
   end

   // reset cause: set by the monitor reset, cleared by a byte write of 0; set wins
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         cause_r <= 1'b0;
      end
      else if (monitor_reset)
      begin
         cause_r <= 1'b1;
      end
      else if (WR && hit_cause && !BIT_WR && !WDATA[CAUSE_SUPPLY_BIT])
      begin
         cause_r <= 1'b0;
      end
   end

   // interrupt status: sticky, cleared by reading it; a new event beats the clear
   always_comb
   begin
      irq_set = 8'h00;
      irq_set[IRQ_CROSS_BIT] = cross_event;
      irq_set[IRQ_PROT_BIT] = prot.violation;
      irq_status_nxt = irq_status_r;
      if (RD && hit_irq_status)
      begin
         irq_status_nxt = 8'h00;
      end
      irq_status_nxt = (irq_status_nxt | irq_set) & IRQ_WMASK;
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         irq_status_r <= IRQ_RESET;
      end
      else if (monitor_reset)
      begin
         irq_status_r <= IRQ_RESET;
      end
      else
      begin
         irq_status_r <= irq_status_nxt;
      end
   end

   // interrupt mask: 1 lets the status bit through
   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         irq_mask_r <= IRQ_RESET;
      end
      else if (monitor_reset)
      begin
         irq_mask_r <= IRQ_RESET;
      end
      else if (WR && hit_irq_mask && !BIT_WR)
      begin
         irq_mask_r <= WDATA & IRQ_WMASK;
      end
   end

   assign IRQ = |(irq_status_r & irq_mask_r);

   // read data, valid in the cycle after the read strobe; unmapped reads give zero
   always_comb
   begin
      read_mux = 8'h00;
      if (hit_ctrl)
      begin
         read_mux = ctrl_view;
      end
      else if (hit_level)
      begin
         read_mux = {7'h00, level_r};
      end
      else if (hit_cause)
      begin
         read_mux = {7'h00, cause_r};
      end
      else if (hit_irq_status)
      begin
         read_mux = irq_status_r;
      end
      else if (hit_irq_mask)
      begin
         read_mux = irq_mask_r;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         rdata_r <= 8'h00;
      end
      else if (RD)
      begin
         rdata_r <= read_mux;
      end
      else
      begin
         rdata_r <= 8'h00;
      end
   end

   assign RDATA = rdata_r;
endmodule : supply_monitor

// File: logic/supply_monitor_pkg.sv
// constants, types and register map of the supply voltage monitor
// Behaviour
// - enabled, mode 0: every threshold crossing, falling or rising, raises the crossing interrupt
// - enabled, mode 1: internal reset held while supply is below the threshold
// - each monitor reset sets the low-voltage cause flag in the reset-source register
// - control bit 7 enables monitoring; 0 turns comparator, below flag, reset and crossing events off; IRQ still follows the status
// - control bit 0 reads 1 while below threshold, else 0 or disabled
// - control takes byte and single-bit accesses; the below flag ignores writes
// - control changes only through the protected special-register write sequence
// - control holds 82h after a monitor reset, 00h after any other reset
// - level select kept over monitor reset, 00h otherwise; byte access only
// - level bit 0 picks the threshold: 0 the higher, 1 the lower level
// - enable plus reset mode lock both registers and monitoring until other reset
// - comparison, interrupt and reset keep working in STOP standby mode
package supply_monitor_pkg;
   typedef logic [31:0] addr_t;
   typedef logic [7:0] byte_t;
   typedef logic [2:0] bit_sel_t;

   // register byte addresses
   localparam addr_t CTRL_ADDR = 32'hfffff890;
   localparam addr_t LEVEL_ADDR = 32'hfffff891;
   localparam addr_t CAUSE_ADDR = 32'hfffff8a0;
   localparam addr_t IRQ_STATUS_ADDR = 32'hfffff8a4;
   localparam addr_t IRQ_MASK_ADDR = 32'hfffff8a5;
   localparam addr_t PROT_CMD_ADDR = 32'hfffff8fc;

   // control register fields
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_FLAG_BIT = 0;
   localparam byte_t CTRL_WMASK = 8'h82;
   localparam byte_t CTRL_RESET_OTHER = 8'h00;
   localparam byte_t CTRL_RESET_MONITOR = 8'h82;

   // level select fields
   localparam int LEVEL_BIT = 0;
   localparam byte_t LEVEL_WMASK = 8'h01;
   localparam byte_t LEVEL_RESET_OTHER = 8'h00;

   // reset-source and interrupt fields
   localparam int CAUSE_SUPPLY_BIT = 0;
   localparam int IRQ_CROSS_BIT = 0;
   localparam int IRQ_PROT_BIT = 1;
   localparam byte_t IRQ_WMASK = 8'h03;
   localparam byte_t IRQ_RESET = 8'h00;

   // synchroniser depth for the comparator input
   localparam int SYNC_STAGES = 3;
endpackage : supply_monitor_pkg
